/* mpp_pkg.sv */
// constants for the multiplexed port pin block
package mpp_pkg;
   localparam int AN_W  = 8;
   localparam int IT_W  = 4;
   localparam int TW_W  = 2;
   localparam int KEY_W = 8;
   localparam int CI_W  = 5;
   localparam int EIRQ_N = 5;
   localparam int SYNC_W = AN_W + IT_W + TW_W + KEY_W + CI_W;
   // edge select codes, two bits per edge interrupt
   localparam logic [1:0] EDGE_NONE    = 2'h0;
   localparam logic [1:0] EDGE_RISE    = 2'h1;
   localparam logic [1:0] EDGE_FALL    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;
   // bit positions of special functions
   localparam int TIMER_B_BIT  = 3;
   localparam int CI_IRQ_BIT   = 0;
   localparam int CI_PU_MASK_W = 5;
   localparam logic [CI_PU_MASK_W-1:0] CI_PU_MASK = 5'h01;
   localparam int TW_CLK_BIT   = 0;
   localparam int TW_DAT_BIT   = 1;
   // reset values
   localparam logic [AN_W-1:0]   AN_MODE_RST = 8'hff;
   localparam logic [SYNC_W-1:0] SYNC_RST    = 27'h0000000;
   localparam logic [EIRQ_N-1:0] EIRQ_RST    = 5'h00;
   localparam logic [KEY_W-1:0]  KEY_RST     = 8'h00;
   typedef enum logic [0:0] {
      MPP_PORT_MODE = 1'b0,
      MPP_CTRL_MODE = 1'b1
   } mpp_mode_t;
endpackage

/* mpp_edge_if.sv */
// carrier between the port top and the edge detector
`timescale 1ns/1ns
interface mpp_edge_if;
   import mpp_pkg::*;
   logic [EIRQ_N-1:0]   level;
   logic [2*EIRQ_N-1:0] sel;
   logic [EIRQ_N-1:0]   enable;
   logic [EIRQ_N-1:0]   pulse;
   modport det (input level, input sel, input enable, output pulse);
   modport top (output level, output sel, output enable, input pulse);
endinterface

/* mpp_edge_det.sv */
// selectable edge detector for the external interrupt inputs
`timescale 1ns/1ns
module mpp_edge_det (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   mpp_edge_if.det   edge_if
);
   import mpp_pkg::*;

   logic [EIRQ_N-1:0] prev;
   logic [EIRQ_N-1:0] next_pulse;

   always_comb begin
      for (int i = 0; i < EIRQ_N; i++) begin
         next_pulse[i] = edge_if.enable[i] &
            ((edge_if.sel[2*i+EDGE_RISE_BIT] & edge_if.level[i] & ~prev[i]) |
             (edge_if.sel[2*i+EDGE_FALL_BIT] & ~edge_if.level[i] & prev[i]));
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev <= EIRQ_RST;
      end else if (ce_in) begin
         prev <= edge_if.level;
      end
   end

   // one pulse per valid edge
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         edge_if.pulse <= EIRQ_RST;
      end else if (ce_in) begin
         edge_if.pulse <= next_pulse;
      end
   end
endmodule

/* mpp_top.sv */
// pin level logic of the multiplexed general purpose ports
// Functional notes
// - each pin selects port mode or alternate control mode on its own.
// - analog port has per-bit input or output direction.
// - analog port pins come out of reset in analog input mode.
// - irq/timer port has per-bit direction and per-bit pull-up enable.
// - its edge interrupts select rising, falling or both edges.
// - irq/timer port carries timer b count clock input and timer b output.
// - two-wire port drives low only, open drain, with per-bit direction.
// - in control mode two-wire port carries serial clock and data lines.
// - key port has direction, pull-ups, and key interrupt inputs in control mode.
// - five-pin port has per-bit direction; pull-up only on lowest pin.
// - lowest five-pin port pin is an edge interrupt with selectable edge.
// - system reset input is active low.
`timescale 1ns/1ns
module mpp_top
   import mpp_pkg::*;
(
   input  wire logic                 ref_clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   // analog-capable port
   input  wire logic [AN_W-1:0]      analog_port_digital_req_in,
   input  wire logic [AN_W-1:0]      analog_port_direction_in,
   input  wire logic [AN_W-1:0]      analog_port_data_in,
   input  wire logic [AN_W-1:0]      analog_port_pins_in,
   output logic [AN_W-1:0]           analog_port_pins_out,
   output logic [AN_W-1:0]           analog_port_pins_oe_out,
   output logic [AN_W-1:0]           analog_port_rd_out,
   output logic [AN_W-1:0]           analog_channel_inputs_out,
   // interrupt/timer port
   input  wire logic [IT_W-1:0]      irq_timer_port_ctrl_in,
   input  wire logic [IT_W-1:0]      irq_timer_port_direction_in,
   input  wire logic [IT_W-1:0]      irq_timer_port_pullup_in,
   input  wire logic [IT_W-1:0]      irq_timer_port_data_in,
   input  wire logic [2*IT_W-1:0]    edge_irq_upper_sel_in,
   input  wire logic                 timer_b_output_en_in,
   input  wire logic                 timer_b_output_in,
   input  wire logic [IT_W-1:0]      irq_timer_port_pins_in,
   output logic [IT_W-1:0]           irq_timer_port_pins_out,
   output logic [IT_W-1:0]           irq_timer_port_pins_oe_out,
   output logic [IT_W-1:0]           irq_timer_port_pullup_out,
   output logic [IT_W-1:0]           irq_timer_port_rd_out,
   output logic [IT_W-1:0]           edge_irq_inputs_upper_out,
   output logic                      timer_b_count_clock_out,
   // two-wire port
   input  wire logic [TW_W-1:0]      twowire_port_ctrl_in,
   input  wire logic [TW_W-1:0]      twowire_port_direction_in,
   input  wire logic [TW_W-1:0]      twowire_port_data_in,
   input  wire logic                 twowire_clock_drive_low_in,
   input  wire logic                 twowire_data_drive_low_in,
   input  wire logic [TW_W-1:0]      twowire_port_pins_in,
   output logic [TW_W-1:0]           twowire_port_pins_out,
   output logic [TW_W-1:0]           twowire_port_pins_oe_out,
   output logic [TW_W-1:0]           twowire_port_rd_out,
   output logic                      twowire_clock_line_out,
   output logic                      twowire_data_line_out,
   // key port
   input  wire logic [KEY_W-1:0]     key_port_ctrl_in,
   input  wire logic [KEY_W-1:0]     key_port_direction_in,
   input  wire logic [KEY_W-1:0]     key_port_pullup_in,
   input  wire logic [KEY_W-1:0]     key_port_data_in,
   input  wire logic [KEY_W-1:0]     key_port_pins_in,
   output logic [KEY_W-1:0]          key_port_pins_out,
   output logic [KEY_W-1:0]          key_port_pins_oe_out,
   output logic [KEY_W-1:0]          key_port_pullup_out,
   output logic [KEY_W-1:0]          key_port_rd_out,
   output logic [KEY_W-1:0]          key_irq_out,
   // five-pin port
   input  wire logic [CI_W-1:0]      clock_irq_port_ctrl_in,
   input  wire logic [CI_W-1:0]      clock_irq_port_direction_in,
   input  wire logic [CI_W-1:0]      clock_irq_port_pullup_in,
   input  wire logic [CI_W-1:0]      clock_irq_port_data_in,
   input  wire logic [1:0]           edge_irq_low_sel_in,
   input  wire logic [CI_W-1:0]      clock_irq_port_pins_in,
   output logic [CI_W-1:0]           clock_irq_port_pins_out,
   output logic [CI_W-1:0]           clock_irq_port_pins_oe_out,
   output logic [CI_W-1:0]           clock_irq_port_pullup_out,
   output logic [CI_W-1:0]           clock_irq_port_rd_out,
   output logic                      edge_irq_input_low_out
);
   import mpp_pkg::*;

   // drive enable: output direction (0) in port mode only
   function automatic logic [KEY_W-1:0] port_oe(input logic [KEY_W-1:0] ctrl, input logic [KEY_W-1:0] dir);
      port_oe = ~ctrl & ~dir;
   endfunction

   // pull-up only for input pins in port mode
   function automatic logic [KEY_W-1:0] port_pu(input logic [KEY_W-1:0] ctrl, input logic [KEY_W-1:0] dir,
                                                input logic [KEY_W-1:0] pu);
      port_pu = pu & dir & ~ctrl;
   endfunction

   // read back: pin for inputs, latch for outputs
   function automatic logic [KEY_W-1:0] port_rd(input logic [KEY_W-1:0] dir, input logic [KEY_W-1:0] pin,
                                                input logic [KEY_W-1:0] dat);
      port_rd = (dir & pin) | (~dir & dat);
   endfunction

   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [AN_W-1:0]   an_pin;
   logic [IT_W-1:0]   it_pin;
   logic [TW_W-1:0]   tw_pin;
   logic [KEY_W-1:0]  key_pin;
   logic [CI_W-1:0]   ci_pin;
   logic [AN_W-1:0]   analog_mode;
   logic [KEY_W-1:0]  key_prev;
   logic [KEY_W-1:0]  it_oe_w;
   logic [KEY_W-1:0]  it_pu_w;
   logic [KEY_W-1:0]  it_rd_w;
   logic [KEY_W-1:0]  ci_oe_w;
   logic [KEY_W-1:0]  ci_pu_w;
   logic [KEY_W-1:0]  ci_rd_w;
   logic [KEY_W-1:0]  an_rd_w;
   logic [KEY_W-1:0]  tw_rd_w;
   logic [IT_W-1:0]   next_it_out;
   logic [IT_W-1:0]   next_it_oe;
   logic [TW_W-1:0]   next_tw_oe;

   mpp_edge_if edge_if ();

   mpp_edge_det u_edge (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .edge_if    (edge_if.det)
   );

   // two flip-flop synchroniser for every pin input
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_a <= SYNC_RST;
         sync_b <= SYNC_RST;
      end else if (ce_in) begin
         sync_a <= {analog_port_pins_in, irq_timer_port_pins_in, twowire_port_pins_in,
                    key_port_pins_in, clock_irq_port_pins_in};
         sync_b <= sync_a;
      end
   end

   assign {an_pin, it_pin, tw_pin, key_pin, ci_pin} = sync_b;

   // analog mode per pin, all analog after reset
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         analog_mode <= AN_MODE_RST;
      end else if (ce_in) begin
         analog_mode <= ~analog_port_digital_req_in;
      end
   end

   // analog port drive
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         analog_port_pins_out      <= '0;
         analog_port_pins_oe_out   <= '0;
         analog_port_rd_out        <= '0;
         analog_channel_inputs_out <= AN_MODE_RST;
      end else if (ce_in) begin
         analog_port_pins_out      <= analog_port_data_in;
         analog_port_pins_oe_out   <= port_oe(analog_mode, analog_port_direction_in);
         analog_port_rd_out        <= an_rd_w & ~analog_mode;
         analog_channel_inputs_out <= analog_mode;
      end
   end

   assign an_rd_w = port_rd(analog_port_direction_in, an_pin, analog_port_data_in);

   // interrupt/timer port
   assign it_oe_w = port_oe({4'h0, irq_timer_port_ctrl_in}, {4'h0, irq_timer_port_direction_in});
   assign it_pu_w = port_pu({4'h0, irq_timer_port_ctrl_in}, {4'h0, irq_timer_port_direction_in},
                            {4'h0, irq_timer_port_pullup_in});
   assign it_rd_w = port_rd({4'h0, irq_timer_port_direction_in}, {4'h0, it_pin}, {4'h0, irq_timer_port_data_in});

   always_comb begin
      next_it_out = irq_timer_port_data_in;
      next_it_oe  = it_oe_w[IT_W-1:0];
      // timer b output takes the pin in control mode when timer_b_output_en_in is set
      if (irq_timer_port_ctrl_in[TIMER_B_BIT] && timer_b_output_en_in) begin
         next_it_out[TIMER_B_BIT] = timer_b_output_in;
         next_it_oe[TIMER_B_BIT]  = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_timer_port_pins_out    <= '0;
         irq_timer_port_pins_oe_out <= '0;
         irq_timer_port_pullup_out  <= '0;
         irq_timer_port_rd_out      <= '0;
         timer_b_count_clock_out    <= 1'b0;
      end else if (ce_in) begin
         irq_timer_port_pins_out    <= next_it_out;
         irq_timer_port_pins_oe_out <= next_it_oe;
         irq_timer_port_pullup_out  <= it_pu_w[IT_W-1:0];
         irq_timer_port_rd_out      <= it_rd_w[IT_W-1:0];
         timer_b_count_clock_out    <= irq_timer_port_ctrl_in[TIMER_B_BIT] & ~timer_b_output_en_in
                                       & it_pin[TIMER_B_BIT];
      end
   end

   // edge interrupts: four upper plus the five-pin port low pin
   assign edge_if.level  = {it_pin, ci_pin[CI_IRQ_BIT]};
   assign edge_if.sel    = {edge_irq_upper_sel_in, edge_irq_low_sel_in};
   assign edge_if.enable = {irq_timer_port_ctrl_in, clock_irq_port_ctrl_in[CI_IRQ_BIT]};
   assign edge_irq_inputs_upper_out = edge_if.pulse[EIRQ_N-1:1];
   assign edge_irq_input_low_out    = edge_if.pulse[0];

   // two-wire port: open drain, low side only, pin output always low
   assign tw_rd_w = port_rd({6'h00, twowire_port_direction_in}, {6'h00, tw_pin}, {6'h00, twowire_port_data_in});

   always_comb begin
      next_tw_oe = ~twowire_port_direction_in & ~twowire_port_data_in;
      if (twowire_port_ctrl_in[TW_CLK_BIT]) begin
         next_tw_oe[TW_CLK_BIT] = twowire_clock_drive_low_in;
      end
      if (twowire_port_ctrl_in[TW_DAT_BIT]) begin
         next_tw_oe[TW_DAT_BIT] = twowire_data_drive_low_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         twowire_port_pins_out    <= '0;
         twowire_port_pins_oe_out <= '0;
         twowire_port_rd_out      <= '0;
         twowire_clock_line_out   <= 1'b0;
         twowire_data_line_out    <= 1'b0;
      end else if (ce_in) begin
         twowire_port_pins_out    <= '0;
         twowire_port_pins_oe_out <= next_tw_oe;
         twowire_port_rd_out      <= tw_rd_w[TW_W-1:0];
         twowire_clock_line_out   <= tw_pin[TW_CLK_BIT];
         twowire_data_line_out    <= tw_pin[TW_DAT_BIT];
      end
   end

   // key port, key interrupt on falling edge in control mode
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         key_prev             <= KEY_RST;
         key_port_pins_out    <= '0;
         key_port_pins_oe_out <= '0;
         key_port_pullup_out  <= '0;
         key_port_rd_out      <= '0;
         key_irq_out          <= KEY_RST;
      end else if (ce_in) begin
         key_prev             <= key_pin;
         key_port_pins_out    <= key_port_data_in;
         key_port_pins_oe_out <= port_oe(key_port_ctrl_in, key_port_direction_in);
         key_port_pullup_out  <= port_pu(key_port_ctrl_in, key_port_direction_in, key_port_pullup_in);
         key_port_rd_out      <= port_rd(key_port_direction_in, key_pin, key_port_data_in);
         key_irq_out          <= key_port_ctrl_in & key_prev & ~key_pin;
      end
   end

   // five-pin port
   assign ci_oe_w = port_oe({3'h0, clock_irq_port_ctrl_in}, {3'h0, clock_irq_port_direction_in});
   assign ci_pu_w = port_pu({3'h0, clock_irq_port_ctrl_in}, {3'h0, clock_irq_port_direction_in},
                            {3'h0, clock_irq_port_pullup_in & CI_PU_MASK});
   assign ci_rd_w = port_rd({3'h0, clock_irq_port_direction_in}, {3'h0, ci_pin}, {3'h0, clock_irq_port_data_in});

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clock_irq_port_pins_out    <= '0;
         clock_irq_port_pins_oe_out <= '0;
         clock_irq_port_pullup_out  <= '0;
         clock_irq_port_rd_out      <= '0;
      end else if (ce_in) begin
         clock_irq_port_pins_out    <= clock_irq_port_data_in;
         clock_irq_port_pins_oe_out <= ci_oe_w[CI_W-1:0];
         clock_irq_port_pullup_out  <= ci_pu_w[CI_W-1:0];
         clock_irq_port_rd_out      <= ci_rd_w[CI_W-1:0];
      end
   end
endmodule

/* mpp_board.sv */
// board model: external pull-ups and drivers on the port pins
`timescale 1ns/1ns
module mpp_board (
   input  wire logic       rst_n_in,
   input  wire logic [1:0] tw_oe_in,
   input  wire logic [1:0] tw_ext_low_in,
   input  wire logic [3:0] it_drive_in,
   output logic      [1:0] tw_pins_out,
   output logic      [3:0] it_pins_out
);
   // open-drain lines rest high unless a party sinks them
   assign tw_pins_out = ~(tw_oe_in | tw_ext_low_in);
   // second pin held low while reset is active
   assign it_pins_out = {it_drive_in[3:2], it_drive_in[1] & rst_n_in, it_drive_in[0]};
endmodule

/* mpp_monitor.sv */
// assertion checker for the multiplexed port pin block
`timescale 1ns/1ns
module mpp_monitor
   import mpp_pkg::*;
(
   input wire logic                ref_clk_in,
   input wire logic                rst_n_in,
   input wire logic                ce_in,
   input wire logic [AN_W-1:0]     analog_port_digital_req_in,
   input wire logic [AN_W-1:0]     analog_port_direction_in,
   input wire logic [AN_W-1:0]     analog_port_pins_oe_out,
   input wire logic [AN_W-1:0]     analog_channel_inputs_out,
   input wire logic [IT_W-1:0]     irq_timer_port_ctrl_in,
   input wire logic [IT_W-1:0]     irq_timer_port_direction_in,
   input wire logic [IT_W-1:0]     irq_timer_port_pullup_in,
   input wire logic [IT_W-1:0]     irq_timer_port_pullup_out,
   input wire logic [IT_W-1:0]     irq_timer_port_pins_out,
   input wire logic                timer_b_output_en_in,
   input wire logic                timer_b_output_in,
   input wire logic [TW_W-1:0]     twowire_port_ctrl_in,
   input wire logic                twowire_clock_drive_low_in,
   input wire logic [TW_W-1:0]     twowire_port_pins_out,
   input wire logic [TW_W-1:0]     twowire_port_pins_oe_out,
   input wire logic [CI_W-1:0]     clock_irq_port_pullup_out,
   input wire logic [1:0]          edge_irq_low_sel_in,
   input wire logic                edge_irq_input_low_out,
   input wire logic [KEY_W-1:0]    key_irq_out,
   input wire logic [IT_W-1:0]     edge_irq_inputs_upper_out
);
   logic live;
   // high when the previous edge ran outside reset with ce_in set
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) live <= 1'b0;
      else live <= ce_in;
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // mode register adds one stage ahead of the analog outputs
   a_an_drive_en: assert property (live && $past(live) |->
      analog_port_pins_oe_out == ($past(analog_port_digital_req_in, 2) & ~$past(analog_port_direction_in)))
      else $error("analog drive enable wrong");
   a_an_mode_sel: assert property (live && $past(live) |->
      analog_channel_inputs_out == ~$past(analog_port_digital_req_in, 2))
      else $error("analog mode wrong");
   a_tw_never_high: assert property (twowire_port_pins_out == '0)
      else $error("two-wire pin drives high");
   a_tw_clk_ctrl: assert property (live && $past(twowire_port_ctrl_in[TW_CLK_BIT]) |->
      twowire_port_pins_oe_out[TW_CLK_BIT] == $past(twowire_clock_drive_low_in))
      else $error("two-wire clock sink wrong");
   a_it_pullup_gate: assert property (live |-> irq_timer_port_pullup_out ==
      $past(irq_timer_port_pullup_in & irq_timer_port_direction_in & ~irq_timer_port_ctrl_in))
      else $error("irq port pull-up wrong");
   a_ci_pullup_mask: assert property ((clock_irq_port_pullup_out & ~CI_PU_MASK) == '0)
      else $error("pull-up on upper pins");
   a_timer_out_drive: assert property (live &&
      $past(irq_timer_port_ctrl_in[TIMER_B_BIT] && timer_b_output_en_in) |->
      irq_timer_port_pins_out[TIMER_B_BIT] == $past(timer_b_output_in))
      else $error("timer output pin wrong");
   a_low_irq_gate: assert property (live && edge_irq_input_low_out |-> $past(edge_irq_low_sel_in) != EDGE_NONE)
      else $error("edge pulse with no edge chosen");
   c_low_irq: cover property (edge_irq_input_low_out);
   c_key_irq: cover property (key_irq_out != '0);
   c_upper_irq: cover property (edge_irq_inputs_upper_out != '0);
endmodule
bind mpp_top mpp_monitor i_mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .analog_port_digital_req_in(analog_port_digital_req_in), .analog_port_direction_in(analog_port_direction_in),
   .analog_port_pins_oe_out(analog_port_pins_oe_out), .analog_channel_inputs_out(analog_channel_inputs_out),
   .irq_timer_port_ctrl_in(irq_timer_port_ctrl_in), .irq_timer_port_direction_in(irq_timer_port_direction_in),
   .irq_timer_port_pullup_in(irq_timer_port_pullup_in), .irq_timer_port_pullup_out(irq_timer_port_pullup_out),
   .irq_timer_port_pins_out(irq_timer_port_pins_out), .timer_b_output_en_in(timer_b_output_en_in),
   .timer_b_output_in(timer_b_output_in), .twowire_port_ctrl_in(twowire_port_ctrl_in),
   .twowire_clock_drive_low_in(twowire_clock_drive_low_in), .twowire_port_pins_out(twowire_port_pins_out),
   .twowire_port_pins_oe_out(twowire_port_pins_oe_out), .clock_irq_port_pullup_out(clock_irq_port_pullup_out),
   .edge_irq_low_sel_in(edge_irq_low_sel_in), .edge_irq_input_low_out(edge_irq_input_low_out),
   .key_irq_out(key_irq_out), .edge_irq_inputs_upper_out(edge_irq_inputs_upper_out));

/* tb.sv */
// self-checking bench for the multiplexed port pin block
`timescale 1ns/1ns
module tb;
   import mpp_pkg::*;
   logic ref_clk_in, rst_n_in, ce_in, timer_b_output_en_in, timer_b_output_in, twowire_clock_drive_low_in;
   logic twowire_data_drive_low_in, timer_b_count_clock_out, twowire_clock_line_out, twowire_data_line_out;
   logic edge_irq_input_low_out, lvl, en;
   logic [7:0] analog_port_digital_req_in, analog_port_direction_in, analog_port_data_in, analog_port_pins_in;
   logic [7:0] analog_port_pins_out, analog_port_pins_oe_out, analog_port_rd_out, analog_channel_inputs_out;
   logic [7:0] edge_irq_upper_sel_in, key_port_ctrl_in, key_port_direction_in, key_port_pullup_in, key_port_data_in;
   logic [7:0] key_port_pins_in, key_port_pins_out, key_port_pins_oe_out, key_port_pullup_out, key_port_rd_out;
   logic [7:0] key_irq_out;
   logic [3:0] irq_timer_port_ctrl_in, irq_timer_port_direction_in, irq_timer_port_pullup_in, irq_timer_port_data_in;
   logic [3:0] irq_timer_port_pins_in, irq_timer_port_pins_out, irq_timer_port_pins_oe_out, irq_timer_port_pullup_out;
   logic [3:0] irq_timer_port_rd_out, edge_irq_inputs_upper_out, it_drive;
   logic [1:0] twowire_port_ctrl_in, twowire_port_direction_in, twowire_port_data_in, twowire_port_pins_in, d;
   logic [1:0] twowire_port_pins_out, twowire_port_pins_oe_out, twowire_port_rd_out, edge_irq_low_sel_in, tw_ext_low;
   logic [4:0] clock_irq_port_ctrl_in, clock_irq_port_direction_in, clock_irq_port_pullup_in, clock_irq_port_data_in;
   logic [4:0] clock_irq_port_pins_in, clock_irq_port_pins_out, clock_irq_port_pins_oe_out, clock_irq_port_pullup_out;
   logic [4:0] clock_irq_port_rd_out;
   logic [31:0] lfsr = 32'h000142cd, r;
   logic [13:0] expq[$];
   int errors = 0, total_checks = 0;
   mpp_top i_dut (.*);
   mpp_board i_board (.rst_n_in(rst_n_in), .tw_oe_in(twowire_port_pins_oe_out), .tw_ext_low_in(tw_ext_low),
      .it_drive_in(it_drive), .tw_pins_out(twowire_port_pins_in), .it_pins_out(irq_timer_port_pins_in));
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #2;
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      #1000000;
      errors++;
      end_of_test();
   end
   // interrupt pulses are matched against the oldest expected event
   always @(posedge ref_clk_in) begin
      #1;
      if ({edge_irq_inputs_upper_out, edge_irq_input_low_out, key_irq_out} !== 13'h0000) begin
         if (expq.size() == 0) chk(1, 0);
         else chk({edge_irq_inputs_upper_out, edge_irq_input_low_out, key_irq_out, lvl}, expq.pop_front());
      end
   end
   initial begin
      {rst_n_in, ce_in, timer_b_output_en_in, timer_b_output_in, twowire_clock_drive_low_in, twowire_data_drive_low_in,
       analog_port_digital_req_in, analog_port_direction_in, analog_port_data_in, analog_port_pins_in,
       irq_timer_port_ctrl_in, irq_timer_port_direction_in, irq_timer_port_pullup_in, irq_timer_port_data_in,
       edge_irq_upper_sel_in, twowire_port_ctrl_in, twowire_port_direction_in, twowire_port_data_in,
       key_port_ctrl_in, key_port_direction_in, key_port_pullup_in, key_port_data_in, key_port_pins_in,
       clock_irq_port_ctrl_in, clock_irq_port_direction_in, clock_irq_port_pullup_in, clock_irq_port_data_in,
       edge_irq_low_sel_in, clock_irq_port_pins_in, it_drive, tw_ext_low, lvl} = '0;
      ce_in = 1'b1;
      cyc(5);
      chk(analog_channel_inputs_out, AN_MODE_RST);
      rst_n_in = 1'b1;
      cyc(1);
      chk(analog_channel_inputs_out, 8'hff);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         {analog_port_digital_req_in, analog_port_direction_in, analog_port_data_in, analog_port_pins_in} = r;
         cyc(4);
         chk(analog_port_pins_oe_out, analog_port_digital_req_in & ~analog_port_direction_in);
         chk(analog_channel_inputs_out, AN_W'(~analog_port_digital_req_in));
         chk(analog_port_rd_out, AN_W'(analog_port_digital_req_in & (analog_port_direction_in & analog_port_pins_in
             | ~analog_port_direction_in & analog_port_data_in)));
      end
      r[7:0] = analog_channel_inputs_out;
      ce_in = 1'b0;
      analog_port_digital_req_in = ~analog_port_digital_req_in;
      cyc(2);
      chk(analog_channel_inputs_out, r[7:0]);
      ce_in = 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         {irq_timer_port_ctrl_in, irq_timer_port_direction_in, key_port_ctrl_in, key_port_direction_in,
          key_port_pullup_in} = r;
         r = rnd();
         {key_port_data_in, timer_b_output_in, timer_b_output_en_in, irq_timer_port_pullup_in, clock_irq_port_ctrl_in,
          clock_irq_port_direction_in, clock_irq_port_pullup_in} = r[28:0];
         r = rnd();
         {irq_timer_port_data_in, clock_irq_port_data_in} = r[8:0];
         cyc(1);
         chk(key_port_pullup_out, key_port_pullup_in & key_port_direction_in & ~key_port_ctrl_in);
         chk(irq_timer_port_pullup_out, irq_timer_port_pullup_in & irq_timer_port_direction_in
             & ~irq_timer_port_ctrl_in);
         chk(clock_irq_port_pullup_out, CI_PU_MASK & clock_irq_port_pullup_in & clock_irq_port_direction_in
             & ~clock_irq_port_ctrl_in);
         chk(key_port_pins_oe_out, 8'(~key_port_ctrl_in & ~key_port_direction_in));
         chk(clock_irq_port_pins_oe_out, 5'(~clock_irq_port_ctrl_in & ~clock_irq_port_direction_in));
         chk(key_port_rd_out, key_port_data_in & ~key_port_direction_in);
         chk(irq_timer_port_rd_out, irq_timer_port_data_in & ~irq_timer_port_direction_in);
         chk(clock_irq_port_pins_out, clock_irq_port_data_in);
         if (irq_timer_port_ctrl_in[TIMER_B_BIT] && timer_b_output_en_in)
            chk(irq_timer_port_pins_out[3], timer_b_output_in);
      end
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         {twowire_port_ctrl_in, twowire_port_direction_in, twowire_port_data_in, twowire_clock_drive_low_in,
          twowire_data_drive_low_in, tw_ext_low} = r[9:0];
         d = (twowire_port_ctrl_in & {twowire_data_drive_low_in, twowire_clock_drive_low_in})
             | (~twowire_port_ctrl_in & ~twowire_port_direction_in & ~twowire_port_data_in);
         cyc(5);
         chk(twowire_port_pins_oe_out, d);
         chk({twowire_data_line_out, twowire_clock_line_out}, 2'(~(d | tw_ext_low)));
      end
      {irq_timer_port_ctrl_in, irq_timer_port_direction_in, timer_b_output_en_in} = {4'h8, 4'hf, 1'b0};
      for (int i = 0; i < 4; i++) begin
         it_drive[3] = ~it_drive[3];
         cyc(4);
         chk(timer_b_count_clock_out, it_drive[3]);
      end
      {irq_timer_port_ctrl_in, clock_irq_port_ctrl_in, clock_irq_port_direction_in} = {4'hf, 5'h01, 5'h1f};
      {key_port_ctrl_in, key_port_direction_in} = 16'hffff;
      for (int c = 0; c < 4; c++) begin
         edge_irq_upper_sel_in = {4{2'(c)}};
         edge_irq_low_sel_in = 2'(c);
         cyc(6);
         for (int e = 1; e >= 0; e--) begin
            lvl = e[0];
            en = lvl ? c[EDGE_RISE_BIT] : c[EDGE_FALL_BIT];
            if (en || !lvl) expq.push_back({{5{en}}, lvl ? 8'h00 : 8'hff, lvl});
            {it_drive, clock_irq_port_pins_in[0], key_port_pins_in} = {{5{lvl}}, {8{lvl}}};
            cyc(6);
         end
      end
      rst_n_in = 1'b0;
      #1;
      chk(analog_channel_inputs_out, 8'hff);
      chk(key_port_pullup_out, 8'h00);
      chk(analog_port_pins_out, 8'h00);
      cyc(1);
      rst_n_in = 1'b1;
      cyc(2);
      for (int k = 0; k < 20 && expq.size() > 0; k++) cyc(1);
      chk(expq.size(), 0);
      end_of_test();
   end
endmodule
